// ### hw/cycle_timing_pkg.sv
// constants, types and encodings shared by the instruction cycle timing block
package cycle_timing_pkg;

   // =====================================================================
   // widths
   localparam int OPCODE_W = 8;
   localparam int COUNT_W  = 4;
   localparam int BYTES_W  = 2;

   // =====================================================================
   // program byte lengths
   localparam logic [BYTES_W-1:0] BYTES_ONE   = 2'h1;
   localparam logic [BYTES_W-1:0] BYTES_TWO   = 2'h2;
   localparam logic [BYTES_W-1:0] BYTES_THREE = 2'h3;

   // =====================================================================
   // execution lengths in system clock cycles (branches: the not-taken figure)
   localparam logic [COUNT_W-1:0] CYC_ONE   = 4'h1;
   localparam logic [COUNT_W-1:0] CYC_TWO   = 4'h2;
   localparam logic [COUNT_W-1:0] CYC_THREE = 4'h3;
   localparam logic [COUNT_W-1:0] CYC_FOUR  = 4'h4;
   localparam logic [COUNT_W-1:0] CYC_FIVE  = 4'h5;
   localparam logic [COUNT_W-1:0] CYC_EIGHT = 4'h8;
   localparam logic [COUNT_W-1:0] CYC_MAX   = CYC_EIGHT;
   // a taken conditional branch runs this many cycles past its base figure
   localparam logic [COUNT_W-1:0] CYC_TAKEN_EXTRA = 4'h1;
   // memory side strobes fire in this execute cycle index
   localparam logic [COUNT_W-1:0] ACCESS_INDEX = 4'h1;
   localparam logic [COUNT_W-1:0] COUNT_ZERO   = 4'h0;
   localparam logic [COUNT_W-1:0] COUNT_STEP   = 4'h1;

   // =====================================================================
   // opcode map columns used by the decoder
   localparam logic [3:0] COL_RN    = 4'h8;
   localparam logic [3:0] COL_IND0  = 4'h6;
   localparam logic [3:0] COL_IND1  = 4'h7;
   localparam logic [3:0] COL_DIR   = 4'h5;
   localparam logic [3:0] COL_IMM   = 4'h4;
   localparam logic [3:0] COL_X3    = 4'h3;
   localparam logic [3:0] COL_X2    = 4'h2;
   localparam logic [3:0] COL_ABS   = 4'h1;
   localparam logic [3:0] COL_X0    = 4'h0;

   // =====================================================================
   // memory side access class of an instruction
   typedef enum logic [2:0] {
      ACC_NONE     = 3'h0,
      ACC_IRAM_IND = 3'h1,
      ACC_XDATA_RD = 3'h2,
      ACC_XDATA_WR = 3'h3,
      ACC_CODE_RD  = 3'h4
   } access_class_type;

   // timing record produced for every opcode
   typedef struct packed {
      logic                  cond;
      access_class_type      access;
      logic [BYTES_W-1:0]    bytes;
      logic [COUNT_W-1:0]    cycles;
   } timing_info_type;

   // sequencer states, gray coded along idle -> execute -> extend
   typedef enum logic [1:0] {
      ST_IDLE   = 2'h0,
      ST_EXEC   = 2'h1,
      ST_EXTEND = 2'h3
   } seq_state_type;

endpackage

// ### hw/exec_cycle_counter.sv
// execute cycle counter holding the limit of the running instruction
`timescale 1ns/100ps
module exec_cycle_counter (
   // clock and reset
   input  wire logic                                clk_sys,
   input  wire logic                                rst_n,
   // control
   input  wire logic                                start,
   input  wire logic                                step,
   input  wire logic [cycle_timing_pkg::COUNT_W-1:0] limit,
   // state
   output logic      [cycle_timing_pkg::COUNT_W-1:0] count_ff,
   output logic                                     last
);

   // =====================================================================
   // counter
   logic [cycle_timing_pkg::COUNT_W-1:0] limit_ff;
   logic [cycle_timing_pkg::COUNT_W-1:0] nxt_count;

   // start wins over step so a back to back load restarts at index zero
   assign nxt_count = start ? cycle_timing_pkg::COUNT_ZERO :
                      step  ? count_ff + cycle_timing_pkg::COUNT_STEP : count_ff;
   // last base cycle of the instruction in flight
   assign last = (count_ff == limit_ff - cycle_timing_pkg::COUNT_STEP);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count_ff <= cycle_timing_pkg::COUNT_ZERO;
         limit_ff <= cycle_timing_pkg::CYC_ONE;
      end else begin
         count_ff <= nxt_count;
         if (start) begin
            limit_ff <= limit;
         end
      end
   end

endmodule // exec_cycle_counter

// ### hw/instruction_cycle_timing.sv
// opcode timing decoder and execute sequencer of the pipelined 8-bit core
`timescale 1ns/100ps

// Overview of operation
// - durations are counted directly in system clock cycles, no machine cycles.
// - most instructions take as many cycles as program bytes, fetch overlapped.
// - a conditional branch not taken ends one cycle before the taken case.
// - one-byte arithmetic on a working register takes one cycle.
// - one-byte arithmetic through an indirect pointer register takes two cycles.
// - subtract with borrow from a direct byte is two bytes, two cycles.
// - logic op of immediate into direct byte is three bytes, three cycles.
// - rotate of the accumulator through carry takes one cycle.
// - move direct byte to direct byte is three bytes, three cycles.
// - move direct byte to indirect RAM is two bytes, two cycles.
// - load of the 16-bit data pointer with a constant takes three cycles.
// - code byte read indexed by data pointer or program counter takes three cycles.
// - external data reads and writes, either pointer, take three cycles.
// - push and pop of a direct byte are two bytes, two cycles.
// - exchange accumulator with a direct byte is two bytes, two cycles.
// - low nibble exchange with indirect RAM is one byte, two cycles.
// - no instruction runs longer than eight cycles.
// - jump on carry takes two cycles not taken, three cycles taken.
module instruction_cycle_timing (
   // clock and reset
   input  wire logic                                  clk_sys,
   input  wire logic                                  nrst,
   // opcode stream from the fetch unit
   input  wire logic [cycle_timing_pkg::OPCODE_W-1:0] opcode,
   input  wire logic                                  opcode_valid,
   output logic                                       opcode_ready,
   // branch condition from the execute unit
   output logic                                       cond_eval,
   input  wire logic                                  branch_cond,
   // program memory operand fetch
   output logic                                       byte_fetch_req,
   // data memory strobes
   output logic                                       iram_access_ff,
   output logic                                       xdata_rd_ff,
   output logic                                       xdata_wr_ff,
   output logic                                       code_rd_ff,
   // retirement report
   output logic                                       instr_busy,
   output logic                                       instr_done_ff,
   output logic                                       branch_taken_ff,
   output logic      [cycle_timing_pkg::COUNT_W-1:0]  instr_cycles_ff
);

   // =====================================================================
   // timing decoder
   // builds one timing record
   function automatic cycle_timing_pkg::timing_info_type mk(
      input logic [cycle_timing_pkg::BYTES_W-1:0] b,
      input logic [cycle_timing_pkg::COUNT_W-1:0] c,
      input logic                                 cd,
      input cycle_timing_pkg::access_class_type   ac);
      cycle_timing_pkg::timing_info_type r;
      r.bytes  = b;
      r.cycles = c;
      r.cond   = cd;
      r.access = ac;
      return r;
   endfunction

   // byte length and cycle count of every opcode; cycles are counted in
   // plain system clocks, so each figure is the whole not-taken duration
   function automatic cycle_timing_pkg::timing_info_type decode(
      input logic [cycle_timing_pkg::OPCODE_W-1:0] op);
      logic [3:0] hi;
      logic [3:0] lo;
      cycle_timing_pkg::timing_info_type r;
      hi = op[7:4];
      lo = op[3:0];
      r  = mk(cycle_timing_pkg::BYTES_ONE, cycle_timing_pkg::CYC_ONE, 1'b0,
              cycle_timing_pkg::ACC_NONE);
      if (lo >= cycle_timing_pkg::COL_RN) begin
         // working register column: one byte ops finish in one cycle
         unique case (hi)
            4'h7, 4'h8, 4'ha: r = mk(cycle_timing_pkg::BYTES_TWO, cycle_timing_pkg::CYC_TWO,
                                     1'b0, cycle_timing_pkg::ACC_NONE);
            4'hb: r = mk(cycle_timing_pkg::BYTES_THREE, cycle_timing_pkg::CYC_THREE,
                         1'b1, cycle_timing_pkg::ACC_NONE);
            4'hd: r = mk(cycle_timing_pkg::BYTES_TWO, cycle_timing_pkg::CYC_TWO,
                         1'b1, cycle_timing_pkg::ACC_NONE);
            default: r = mk(cycle_timing_pkg::BYTES_ONE, cycle_timing_pkg::CYC_ONE,
                            1'b0, cycle_timing_pkg::ACC_NONE);
         endcase
      end else if (lo == cycle_timing_pkg::COL_IND0 || lo == cycle_timing_pkg::COL_IND1) begin
         // indirect column: the RAM read costs one cycle past the byte count in the one and three byte forms
         unique case (hi)
            4'h7, 4'h8, 4'ha: r = mk(cycle_timing_pkg::BYTES_TWO, cycle_timing_pkg::CYC_TWO,
                                     1'b0, cycle_timing_pkg::ACC_IRAM_IND);
            4'hb: r = mk(cycle_timing_pkg::BYTES_THREE, cycle_timing_pkg::CYC_FOUR,
                         1'b1, cycle_timing_pkg::ACC_IRAM_IND);
            default: r = mk(cycle_timing_pkg::BYTES_ONE, cycle_timing_pkg::CYC_TWO,
                            1'b0, cycle_timing_pkg::ACC_IRAM_IND);
         endcase
      end else if (lo == cycle_timing_pkg::COL_DIR) begin
         unique case (hi)
            4'h7, 4'h8: r = mk(cycle_timing_pkg::BYTES_THREE, cycle_timing_pkg::CYC_THREE,
                               1'b0, cycle_timing_pkg::ACC_NONE);
            4'ha: r = mk(cycle_timing_pkg::BYTES_ONE, cycle_timing_pkg::CYC_ONE,
                         1'b0, cycle_timing_pkg::ACC_NONE);
            4'hb, 4'hd: r = mk(cycle_timing_pkg::BYTES_THREE, cycle_timing_pkg::CYC_THREE,
                               1'b1, cycle_timing_pkg::ACC_NONE);
            default: r = mk(cycle_timing_pkg::BYTES_TWO, cycle_timing_pkg::CYC_TWO,
                            1'b0, cycle_timing_pkg::ACC_NONE);
         endcase
      end else if (lo == cycle_timing_pkg::COL_IMM) begin
         unique case (hi)
            4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9:
               r = mk(cycle_timing_pkg::BYTES_TWO, cycle_timing_pkg::CYC_TWO,
                      1'b0, cycle_timing_pkg::ACC_NONE);
            4'h8: r = mk(cycle_timing_pkg::BYTES_ONE, cycle_timing_pkg::CYC_EIGHT,
                         1'b0, cycle_timing_pkg::ACC_NONE);
            4'ha: r = mk(cycle_timing_pkg::BYTES_ONE, cycle_timing_pkg::CYC_FOUR,
                         1'b0, cycle_timing_pkg::ACC_NONE);
            4'hb: r = mk(cycle_timing_pkg::BYTES_THREE, cycle_timing_pkg::CYC_THREE,
                         1'b1, cycle_timing_pkg::ACC_NONE);
            default: r = mk(cycle_timing_pkg::BYTES_ONE, cycle_timing_pkg::CYC_ONE,
                            1'b0, cycle_timing_pkg::ACC_NONE);
         endcase
      end else if (lo == cycle_timing_pkg::COL_X3) begin
         unique case (hi)
            4'h4, 4'h5, 4'h6: r = mk(cycle_timing_pkg::BYTES_THREE, cycle_timing_pkg::CYC_THREE,
                                     1'b0, cycle_timing_pkg::ACC_NONE);
            4'h7: r = mk(cycle_timing_pkg::BYTES_ONE, cycle_timing_pkg::CYC_THREE,
                         1'b0, cycle_timing_pkg::ACC_NONE);
            4'h8, 4'h9: r = mk(cycle_timing_pkg::BYTES_ONE, cycle_timing_pkg::CYC_THREE,
                               1'b0, cycle_timing_pkg::ACC_CODE_RD);
            4'he: r = mk(cycle_timing_pkg::BYTES_ONE, cycle_timing_pkg::CYC_THREE,
                         1'b0, cycle_timing_pkg::ACC_XDATA_RD);
            4'hf: r = mk(cycle_timing_pkg::BYTES_ONE, cycle_timing_pkg::CYC_THREE,
                         1'b0, cycle_timing_pkg::ACC_XDATA_WR);
            default: r = mk(cycle_timing_pkg::BYTES_ONE, cycle_timing_pkg::CYC_ONE,
                            1'b0, cycle_timing_pkg::ACC_NONE);
         endcase
      end else if (lo == cycle_timing_pkg::COL_X2) begin
         unique case (hi)
            4'h0, 4'h1: r = mk(cycle_timing_pkg::BYTES_THREE, cycle_timing_pkg::CYC_FOUR,
                               1'b0, cycle_timing_pkg::ACC_NONE);
            4'h2, 4'h3: r = mk(cycle_timing_pkg::BYTES_ONE, cycle_timing_pkg::CYC_FIVE,
                               1'b0, cycle_timing_pkg::ACC_NONE);
            4'he: r = mk(cycle_timing_pkg::BYTES_ONE, cycle_timing_pkg::CYC_THREE,
                         1'b0, cycle_timing_pkg::ACC_XDATA_RD);
            4'hf: r = mk(cycle_timing_pkg::BYTES_ONE, cycle_timing_pkg::CYC_THREE,
                         1'b0, cycle_timing_pkg::ACC_XDATA_WR);
            default: r = mk(cycle_timing_pkg::BYTES_TWO, cycle_timing_pkg::CYC_TWO,
                            1'b0, cycle_timing_pkg::ACC_NONE);
         endcase
      end else if (lo == cycle_timing_pkg::COL_ABS) begin
         // absolute jump and call
         r = mk(cycle_timing_pkg::BYTES_TWO, cycle_timing_pkg::CYC_THREE, 1'b0,
                cycle_timing_pkg::ACC_NONE);
      end else begin
         unique case (hi)
            4'h0: r = mk(cycle_timing_pkg::BYTES_ONE, cycle_timing_pkg::CYC_ONE,
                         1'b0, cycle_timing_pkg::ACC_NONE);
            4'h1, 4'h2, 4'h3: r = mk(cycle_timing_pkg::BYTES_THREE, cycle_timing_pkg::CYC_THREE,
                                     1'b1, cycle_timing_pkg::ACC_NONE);
            4'h4, 4'h5, 4'h6, 4'h7: r = mk(cycle_timing_pkg::BYTES_TWO, cycle_timing_pkg::CYC_TWO,
                                           1'b1, cycle_timing_pkg::ACC_NONE);
            4'h8: r = mk(cycle_timing_pkg::BYTES_TWO, cycle_timing_pkg::CYC_THREE,
                         1'b0, cycle_timing_pkg::ACC_NONE);
            4'h9: r = mk(cycle_timing_pkg::BYTES_THREE, cycle_timing_pkg::CYC_THREE,
                         1'b0, cycle_timing_pkg::ACC_NONE);
            4'he: r = mk(cycle_timing_pkg::BYTES_ONE, cycle_timing_pkg::CYC_THREE,
                         1'b0, cycle_timing_pkg::ACC_XDATA_RD);
            4'hf: r = mk(cycle_timing_pkg::BYTES_ONE, cycle_timing_pkg::CYC_THREE,
                         1'b0, cycle_timing_pkg::ACC_XDATA_WR);
            default: r = mk(cycle_timing_pkg::BYTES_TWO, cycle_timing_pkg::CYC_TWO,
                            1'b0, cycle_timing_pkg::ACC_NONE);
         endcase
      end
      return r;
   endfunction

   // =====================================================================
   // reset release
   logic rst_n;

   reset_sync u_reset_sync (
      .clk_sys    (clk_sys),
      .nrst       (nrst),
      .rst_sync_n (rst_n)
   );

   // =====================================================================
   // declarations
   cycle_timing_pkg::seq_state_type          state_ff;
   cycle_timing_pkg::seq_state_type          nxt_state;
   cycle_timing_pkg::timing_info_type        new_info;
   logic                                     cond_ff;
   cycle_timing_pkg::access_class_type       access_ff;
   logic [cycle_timing_pkg::BYTES_W-1:0]     bytes_ff;
   logic [cycle_timing_pkg::COUNT_W-1:0]     count;
   logic                                     base_last;
   logic                                     accept;
   logic                                     in_exec;
   logic                                     in_extend;
   logic                                     take_branch;
   logic                                     finishing;
   logic                                     step;
   logic                                     at_access;

   // =====================================================================
   // handshake and sequencing terms
   assign new_info    = decode(opcode);
   assign in_exec     = (state_ff == cycle_timing_pkg::ST_EXEC);
   assign in_extend   = (state_ff == cycle_timing_pkg::ST_EXTEND);
   assign instr_busy  = in_exec || in_extend;
   // the condition is asked for on the last base cycle only
   assign cond_eval   = in_exec && base_last && cond_ff;
   assign take_branch = cond_eval && branch_cond;
   // a not taken branch ends on its base figure, a taken one runs one more
   assign finishing   = (in_exec && base_last && !take_branch) || in_extend;
   // next opcode is taken in the final cycle, so fetch overlaps execution
   assign opcode_ready = (state_ff == cycle_timing_pkg::ST_IDLE) || finishing;
   assign accept       = opcode_valid && opcode_ready;
   assign step         = in_exec && !base_last || take_branch;
   // operand bytes are fetched in the cycles before the last program byte
   assign byte_fetch_req = in_exec && ({2'h0, bytes_ff} > count + cycle_timing_pkg::COUNT_STEP);
   assign at_access      = in_exec && (count == cycle_timing_pkg::COUNT_ZERO);

   // =====================================================================
   // cycle counter: every clock is one unit of duration, never grouped
   exec_cycle_counter u_exec_cycle_counter (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .start    (accept),
      .step     (step),
      .limit    (new_info.cycles),
      .count_ff (count),
      .last     (base_last)
   );

   // =====================================================================
   // state machine
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         cycle_timing_pkg::ST_IDLE: begin
            if (accept) begin
               nxt_state = cycle_timing_pkg::ST_EXEC;
            end
         end
         cycle_timing_pkg::ST_EXEC: begin
            if (take_branch) begin
               nxt_state = cycle_timing_pkg::ST_EXTEND;
            end else if (base_last) begin
               nxt_state = accept ? cycle_timing_pkg::ST_EXEC : cycle_timing_pkg::ST_IDLE;
            end
         end
         cycle_timing_pkg::ST_EXTEND: begin
            nxt_state = accept ? cycle_timing_pkg::ST_EXEC : cycle_timing_pkg::ST_IDLE;
         end
         default: nxt_state = cycle_timing_pkg::ST_IDLE;
      endcase
   end

   // state and instruction record
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_ff  <= cycle_timing_pkg::ST_IDLE;
         cond_ff   <= 1'b0;
         access_ff <= cycle_timing_pkg::ACC_NONE;
         bytes_ff  <= cycle_timing_pkg::BYTES_ONE;
      end else begin
         state_ff <= nxt_state;
         if (accept) begin
            cond_ff   <= new_info.cond;
            access_ff <= new_info.access;
            bytes_ff  <= new_info.bytes;
         end
      end
   end

   // =====================================================================
   // data memory strobes, high during execute index one
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         iram_access_ff <= 1'b0;
         xdata_rd_ff    <= 1'b0;
         xdata_wr_ff    <= 1'b0;
         code_rd_ff     <= 1'b0;
      end else begin
         iram_access_ff <= at_access && access_ff == cycle_timing_pkg::ACC_IRAM_IND;
         xdata_rd_ff    <= at_access && access_ff == cycle_timing_pkg::ACC_XDATA_RD;
         xdata_wr_ff    <= at_access && access_ff == cycle_timing_pkg::ACC_XDATA_WR;
         code_rd_ff     <= at_access && access_ff == cycle_timing_pkg::ACC_CODE_RD;
      end
   end

   // =====================================================================
   // retirement report, one cycle after the final cycle
   // the count never passes the table maximum, so the report fits its width
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         instr_done_ff   <= 1'b0;
         branch_taken_ff <= 1'b0;
         instr_cycles_ff <= cycle_timing_pkg::COUNT_ZERO;
      end else begin
         instr_done_ff <= finishing;
         if (finishing) begin
            branch_taken_ff <= in_extend;
            instr_cycles_ff <= count + cycle_timing_pkg::COUNT_STEP;
         end
      end
   end

endmodule // instruction_cycle_timing

// ### hw/reset_sync.sv
// two flip-flop release synchroniser for the active low core reset
`timescale 1ns/100ps
module reset_sync (
   // clock and raw reset
   input  wire logic clk_sys,
   input  wire logic nrst,
   // synchronised reset
   output logic      rst_sync_n
);

   // =====================================================================
   // synchroniser
   logic stage_ff;

   // assert at once, release only after two clean edges
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         stage_ff   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         stage_ff   <= 1'b1;
         rst_sync_n <= stage_ff;
      end
   end

endmodule // reset_sync

// ### test/exec_unit_model.sv
// execute unit model answering branch condition queries
`timescale 1ns/100ps
module exec_unit_model (
   // clock, query and answer
   input  wire logic clk_sys,
   input  wire logic cond_eval,
   input  wire logic take,
   output logic      branch_cond
);
   logic toggle_ff = 1'b0;
   // junk outside a query, so a design sampling early goes wrong
   always @(posedge clk_sys) begin
      toggle_ff <= !toggle_ff;
   end
   assign branch_cond = cond_eval ? take : toggle_ff;
endmodule // exec_unit_model

// ### test/instruction_cycle_timing_bench.sv
// self-checking bench for the instruction cycle timing block
`timescale 1ns/100ps
module instruction_cycle_timing_bench;
   logic       clk_sys = 1'b0, nrst = 1'b0, opcode_valid = 1'b0, take = 1'b0;
   logic [7:0] opcode = 8'h00;
   logic       branch_cond, cond_eval, opcode_ready, byte_fetch_req, instr_done_ff;
   logic       iram_access_ff, xdata_rd_ff, xdata_wr_ff, code_rd_ff, branch_taken_ff, instr_busy;
   logic [3:0] instr_cycles_ff, strobes;
   int         mismatches = 0, compares = 0;
   always #4 clk_sys = !clk_sys;
   instruction_cycle_timing i_dut (.clk_sys(clk_sys), .nrst(nrst), .opcode(opcode),
      .opcode_valid(opcode_valid), .opcode_ready(opcode_ready), .cond_eval(cond_eval),
      .branch_cond(branch_cond), .byte_fetch_req(byte_fetch_req), .instr_busy(instr_busy),
      .iram_access_ff(iram_access_ff), .xdata_rd_ff(xdata_rd_ff), .xdata_wr_ff(xdata_wr_ff),
      .code_rd_ff(code_rd_ff), .instr_done_ff(instr_done_ff),
      .branch_taken_ff(branch_taken_ff), .instr_cycles_ff(instr_cycles_ff));
   exec_unit_model i_exec (.clk_sys(clk_sys), .cond_eval(cond_eval), .take(take),
      .branch_cond(branch_cond));
   // ====
   // compares, one per kind of result
   task automatic check_count(input string what, input logic [3:0] exp, got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic check_flag(input string what, input logic exp, got);
      check_count(what, {3'h0, exp}, {3'h0, got});
   endtask
   // one instruction; entered just after an edge, counts edges until retirement
   task automatic run(input logic [7:0] op, input logic tk, input logic [3:0] cyc);
      logic [3:0] n;
      logic [3:0] nb;
      n = 4'h0;
      nb = 4'h0;
      strobes = 4'h0;
      opcode = op;
      opcode_valid = 1'b1;
      take = tk;
      @(posedge clk_sys);
      #1 opcode_valid = 1'b0;
      while (instr_done_ff !== 1'b1 && n < 4'hf) begin
         strobes = strobes | {iram_access_ff, xdata_rd_ff, xdata_wr_ff, code_rd_ff};
         nb = nb + {3'h0, instr_busy};
         @(posedge clk_sys);
         #1 n++;
      end
      check_count("duration", cyc, n);
      check_count("busy cycles", cyc, nb);
      check_count("reported length", cyc, instr_cycles_ff);
      check_flag("taken report", tk, branch_taken_ff);
   endtask
   // fixed-length instructions, register, indirect, direct and long forms
   task automatic test_plain;
      logic [7:0] ops [14] = '{8'h38, 8'h33, 8'h26, 8'h95, 8'h53, 8'h85, 8'ha6,
                               8'h90, 8'hc0, 8'hd0, 8'hc5, 8'hd6, 8'ha4, 8'h84};
      logic [3:0] cyc [14] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h2,
                               4'h3, 4'h2, 4'h2, 4'h2, 4'h2, 4'h4, 4'h8};
      for (int i = 0; i < 14; i++) begin
         run(ops[i], 1'b0, cyc[i]);
      end
   endtask
   // external data, code and indirect RAM accesses, each with its own strobe
   task automatic test_memory;
      logic [7:0] ops [7] = '{8'he2, 8'he0, 8'hf2, 8'hf0, 8'h93, 8'h83, 8'h26};
      logic [3:0] exp [7] = '{4'h4, 4'h4, 4'h2, 4'h2, 4'h1, 4'h1, 4'h8};
      for (int i = 0; i < 7; i++) begin
         run(ops[i], 1'b0, (i < 6) ? 4'h3 : 4'h2);
         check_count("strobes", exp[i], strobes);
      end
   endtask
   // carry jumps, not taken then taken
   task automatic test_branch;
      run(8'h40, 1'b0, 4'h2);
      run(8'h40, 1'b1, 4'h3);
      run(8'h50, 1'b1, 4'h3);
   endtask
   task automatic give_verdict;
      if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // main sequence after a two cycle reset
   initial begin
      repeat (2) @(posedge clk_sys);
      #1 nrst = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 test_plain();
      test_memory();
      test_branch();
      give_verdict();
   end
   // watchdog, well past the fewer than a hundred cycles the tests need
   initial begin
      #20000 mismatches++;
      give_verdict();
   end
endmodule // instruction_cycle_timing_bench
bind instruction_cycle_timing timing_checker i_chk (.clk_sys(clk_sys), .nrst(nrst),
   .opcode_valid(opcode_valid), .opcode_ready(opcode_ready), .cond_eval(cond_eval),
   .branch_cond(branch_cond), .byte_fetch_req(byte_fetch_req), .xdata_rd_ff(xdata_rd_ff),
   .instr_done_ff(instr_done_ff), .branch_taken_ff(branch_taken_ff), .opcode(opcode),
   .instr_cycles_ff(instr_cycles_ff));

// ### test/timing_checker_sva.sv
// assertion checker for the instruction cycle timing block
`timescale 1ns/100ps
module timing_checker (
   // watched ports
   input wire logic       clk_sys, nrst, opcode_valid, opcode_ready, cond_eval,
   input wire logic       branch_cond, byte_fetch_req, xdata_rd_ff, instr_done_ff,
   input wire logic       branch_taken_ff,
   input wire logic [7:0] opcode,
   input wire logic [3:0] instr_cycles_ff
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // ====
   // an opcode taken, and a retirement with its length
   sequence take_s(logic [7:0] op);
      opcode_valid && opcode_ready && opcode == op;
   endsequence
   sequence done_s(logic [3:0] n);
      instr_done_ff && instr_cycles_ff == n;
   endsequence
   a_cycles_max: assert property (instr_done_ff |-> instr_cycles_ff inside {[1:8]})
      else $error("retired length out of range");
   a_reg_one: assert property (take_s(8'h38) |-> ##2 done_s(4'h1))
      else $error("register add length wrong");
   a_ind_two: assert property (take_s(8'h26) |-> ##3 done_s(4'h2))
      else $error("indirect add length wrong");
   a_borrow_dir: assert property (take_s(8'h95) |-> ##1 byte_fetch_req ##2 done_s(4'h2))
      else $error("direct subtract timing wrong");
   a_move_dd: assert property (take_s(8'h85) |-> ##1 byte_fetch_req [*2]
      ##1 !byte_fetch_req ##1 done_s(4'h3))
      else $error("direct move timing wrong");
   a_xdata_read: assert property (take_s(8'he2) |-> ##2 xdata_rd_ff ##2 done_s(4'h3))
      else $error("external read timing wrong");
   a_mul_four: assert property (take_s(8'ha4) |-> ##5 done_s(4'h4))
      else $error("multiply length wrong");
   a_div_eight: assert property (take_s(8'h84) |-> ##9 done_s(4'h8))
      else $error("divide length wrong");
   a_branch_not: assert property (cond_eval && !branch_cond |-> opcode_ready
      ##1 instr_done_ff && !branch_taken_ff)
      else $error("untaken branch not shortened");
   a_branch_taken: assert property (cond_eval && branch_cond |-> !opcode_ready
      ##2 instr_done_ff && branch_taken_ff)
      else $error("taken branch lacks extra cycle");
endmodule // timing_checker
